// *** kbe_pkg.sv ***
// Constants, types and key state layout for the keyboard encoder and controller.
// Assumes a single 100 MHz clock and an asynchronous active-high reset.
//
// Function
// (RQ1) Key closure yields fixed seven-bit ROM code
// (RQ2) Key press activates the data strobe
// (RQ3) Interlocked second key within 35 ms: no character
// (RQ4) Strobe idles high, asserted low
// (RQ5) Strobe delayed under 5 ms after press
// (RQ6) Strobe falling edge sets first ready
// (RQ7) Next phase-2 sets second ready
// (RQ8) Second ready passes select or interrupts
// (RQ9) Addressed read while ready: acknowledge, drive code
// (RQ10) Function 02 masks, 03 unmasks interrupt
// (RQ11) Write acknowledged always, test when present
// (RQ12) Repeat write plus held key re-sets ready
// (RQ13) Served read clears first ready on T2
// (RQ14) Phase-2 after ready one clears ready two
package kbe_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int KBE_CLK_MHZ         = 100;
  localparam int KBE_STROBE_DELAY_US = 4000;
  localparam int KBE_STROBE_DELAY_CYC = KBE_STROBE_DELAY_US * KBE_CLK_MHZ;
  localparam int KBE_INTERLOCK_MS    = 35;
  localparam int KBE_INTERLOCK_CYC   = KBE_INTERLOCK_MS * 1000 * KBE_CLK_MHZ;
  localparam int KBE_CNT_W           = 22;

  localparam logic [1:0] KBE_PHASE_LAST  = 2'h3;
  localparam logic [1:0] KBE_PHASE2_SLOT = 2'h1;
  localparam logic [1:0] KBE_T2_SLOT     = 2'h3;

  // ****************************************************************
  // Keys and codes
  // ****************************************************************
  localparam int KBE_NUM_KEYS = 68;
  localparam int KBE_IDX_W    = 7;
  localparam int KBE_CODE_W   = 7;
  localparam int KBE_HOST_FUNCTION_CODE_W   = 4;
  localparam int KBE_BUS_W    = 8;

  localparam logic [KBE_HOST_FUNCTION_CODE_W-1:0] KBE_HOST_FUNCTION_CODE_MASK   = 4'h2;
  localparam logic [KBE_HOST_FUNCTION_CODE_W-1:0] KBE_HOST_FUNCTION_CODE_UNMASK = 4'h3;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] KBE_REG_CTRL   = 4'h0;
  localparam logic [3:0] KBE_REG_STATUS = 4'h4;
  localparam logic [3:0] KBE_REG_MASK   = 4'h8;
  localparam logic [3:0] KBE_REG_CODE   = 4'hC;

  localparam int KBE_EV_W        = 3;
  localparam int KBE_EV_STROBE   = 0;
  localparam int KBE_EV_SUPPRESS = 1;
  localparam int KBE_EV_READ     = 2;

  localparam int KBE_CTRL_EN_BIT = 0;
  localparam logic KBE_CTRL_EN_RST = 1'b1;
  localparam logic KBE_MASKFF_RST  = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    KBE_IDLE   = 2'b00,
    KBE_SETTLE = 2'b01,
    KBE_HOLD   = 2'b11,
    KBE_PEND   = 2'b10
  } kbe_enc_e;

  typedef struct packed {
    logic                  read_io;
    logic                  write_io;
    logic                  test_io;
    logic                  host_function_code_io;
    logic                  addr_match;
    logic [KBE_HOST_FUNCTION_CODE_W-1:0] host_function_code;
  } kbe_host_req_s;

  typedef struct packed {
    logic [3:0]           addr;
    logic [KBE_BUS_W-1:0] wdata;
    logic                 wr;
    logic                 rd;
  } kbe_reg_req_s;

  typedef struct packed {
    logic [1:0] cnt;
  } kbe_phase_s;

  typedef struct packed {
    logic [KBE_NUM_KEYS-1:0] keys_s1;
    logic [KBE_NUM_KEYS-1:0] keys_s2;
    logic                    present_s1;
    logic                    present_s2;
    kbe_enc_e                enc;
    logic [KBE_IDX_W-1:0]    first_idx;
    logic [KBE_IDX_W-1:0]    second_idx;
    logic [KBE_CODE_W-1:0]   code;
    logic [KBE_CNT_W-1:0]    settle_cnt;
    logic [KBE_CNT_W-1:0]    win_cnt;
    logic                    strobe_n;
    logic                    strobe_prev_n;
    logic                    ready1;
    logic                    ready2;
    logic                    clear_pend;
    logic                    mask_ff;
    logic                    irq;
    logic                    repeat_en;
    logic [KBE_CODE_W-1:0]   bus_data;
    logic                    ctrl_en;
    logic [KBE_EV_W-1:0]     status;
    logic [KBE_EV_W-1:0]     ev_mask;
    logic [KBE_BUS_W-1:0]    rd_data;
  } kbe_state_s;

endpackage

// *** kbe_phase_gen.sv ***
// Timing phase generator: one-cycle phase-2 and T2 enables from a free counter.
// Assumes the same clock and reset as the controller it feeds.
module kbe_phase_gen (
  input  wire logic clk_in,
  input  wire logic rst_in,
  output logic      phase2_en_out,
  output logic      t2_en_out
);

  kbe_pkg::kbe_phase_s q;
  kbe_pkg::kbe_phase_s d;

  always_comb begin
    d = q;
    d.cnt = (q.cnt == kbe_pkg::KBE_PHASE_LAST) ? 2'h0 : q.cnt + 2'h1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign phase2_en_out = (q.cnt == kbe_pkg::KBE_PHASE2_SLOT);
  assign t2_en_out     = (q.cnt == kbe_pkg::KBE_T2_SLOT);

endmodule

// *** kbe_top.sv ***
// Keyboard encoder with interlock plus its processor-side input controller.
// Assumes key switches and keyboard-present come from pins; host and register
// ports are on the same clock.
//
// The register offsets and the strobed register port were chosen for this implementation.
module kbe_top #(
  parameter int SETTLE_CYCLES    = kbe_pkg::KBE_STROBE_DELAY_CYC,
  parameter int INTERLOCK_CYCLES = kbe_pkg::KBE_INTERLOCK_CYC
) (
  input  wire logic                                clk_in,
  input  wire logic                                rst_in,
  input  wire logic [kbe_pkg::KBE_NUM_KEYS-1:0]    key_switch_in,
  input  wire logic                                keyboard_present_in,
  input  wire logic                                device_type_select_in,
  input  wire logic                                int_sel_in,
  input  wire kbe_pkg::kbe_host_req_s              host_req_in,
  input  wire kbe_pkg::kbe_reg_req_s               reg_req_in,
  output logic [kbe_pkg::KBE_CODE_W-1:0]           key_code_out,
  output logic                                     key_data_strobe_n_out,
  output logic                                     int_sel_out,
  output logic                                     transfer_irq_request_out,
  output logic                                     host_ack_out,
  output logic [kbe_pkg::KBE_BUS_W-1:0]            host_in_bus_out,
  output logic [kbe_pkg::KBE_BUS_W-1:0]            rd_data_out,
  output logic                                     irq_out
);

  // ****************************************************************
  // Key code ROM, index 0 is key 1
  // ****************************************************************
  localparam logic [6:0] KEY_ROM [kbe_pkg::KBE_NUM_KEYS] = '{
    7'h68,
    7'h31,
    7'h32,
    7'h33,
    7'h34,
    7'h35,
    7'h36,
    7'h37,
    7'h38,
    7'h39,
    7'h30,
    7'h2D,
    7'h5E,
    7'h24,
    7'h62,
    7'h65,
    7'h51,
    7'h57,
    7'h45,
    7'h52,
    7'h54,
    7'h59,
    7'h55,
    7'h49,
    7'h4F,
    7'h50,
    7'h3D,
    7'h69,
    7'h61,
    7'h6A,
    7'h2F,
    7'h41,
    7'h53,
    7'h44,
    7'h46,
    7'h47,
    7'h48,
    7'h4A,
    7'h4B,
    7'h4C,
    7'h3A,
    7'h2C,
    7'h6B,
    7'h6F,
    7'h66,
    7'h23,
    7'h5A,
    7'h58,
    7'h43,
    7'h56,
    7'h42,
    7'h4E,
    7'h4D,
    7'h2E,
    7'h2A,
    7'h2B,
    7'h64,
    7'h63,
    7'h6E,
    7'h67,
    7'h60,
    7'h20,
    7'h6D,
    7'h6C,
    7'h27,
    7'h28,
    7'h25,
    7'h29
  };

  localparam logic [kbe_pkg::KBE_CNT_W-1:0] SETTLE_LAST  = kbe_pkg::KBE_CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [kbe_pkg::KBE_CNT_W-1:0] INTERLOCK_LIM = kbe_pkg::KBE_CNT_W'(INTERLOCK_CYCLES);

  kbe_pkg::kbe_state_s q;
  kbe_pkg::kbe_state_s d;

  logic                              phase2_en;
  logic                              t2_en;
  logic                              any_key;
  logic                              other_key;
  logic [kbe_pkg::KBE_IDX_W-1:0]     low_idx;
  logic [kbe_pkg::KBE_IDX_W-1:0]     other_idx;
  logic                              first_held;
  logic                              second_held;
  logic                              gate_open;
  logic                              rd_hit;
  logic                              wr_hit;
  logic                              test_hit;
  logic                              host_function_code_hit;
  logic                              ready1_set;
  logic [kbe_pkg::KBE_EV_W-1:0]      ev;
  logic [kbe_pkg::KBE_EV_W-1:0]      w1c;

  kbe_phase_gen u_phase (
    .clk_in        (clk_in),
    .rst_in        (rst_in),
    .phase2_en_out (phase2_en),
    .t2_en_out     (t2_en)
  );

  // ****************************************************************
  // Key search: lowest closed key and lowest key other than the first
  // ****************************************************************
  always_comb begin
    any_key   = 1'b0;
    other_key = 1'b0;
    low_idx   = '0;
    other_idx = '0;
    for (int i = kbe_pkg::KBE_NUM_KEYS - 1; i >= 0; i--) begin
      if (q.keys_s2[i]) begin
        any_key = 1'b1;
        low_idx = kbe_pkg::KBE_IDX_W'(i);
        if (kbe_pkg::KBE_IDX_W'(i) != q.first_idx) begin
          other_key = 1'b1;
          other_idx = kbe_pkg::KBE_IDX_W'(i);
        end
      end
    end
  end

  assign first_held  = q.keys_s2[q.first_idx];
  assign second_held = q.keys_s2[q.second_idx];

  // ****************************************************************
  // Host decode
  // ****************************************************************
  assign gate_open = q.ready2 & ~q.mask_ff & device_type_select_in;
  assign rd_hit    = host_req_in.read_io & host_req_in.addr_match & q.ready2;
  assign wr_hit    = host_req_in.write_io & host_req_in.addr_match;
  assign test_hit  = host_req_in.test_io & host_req_in.addr_match & q.present_s2;
  assign host_function_code_hit  = host_req_in.host_function_code_io & host_req_in.addr_match;
  assign ready1_set = (q.strobe_prev_n & ~q.strobe_n) | // RQ6
                      (q.repeat_en & ~q.strobe_n & ~q.ready1 & ~q.clear_pend); // RQ12

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d   = q;
    ev  = '0;
    w1c = '0;

    d.keys_s1    = key_switch_in;
    d.keys_s2    = q.keys_s1;
    d.present_s1 = keyboard_present_in;
    d.present_s2 = q.present_s1;

    if (q.win_cnt < INTERLOCK_LIM) begin
      d.win_cnt = q.win_cnt + 22'h1;
    end

    unique case (q.enc)
      kbe_pkg::KBE_IDLE: begin
        if (q.ctrl_en && any_key) begin
          d.first_idx  = low_idx;
          d.code       = KEY_ROM[low_idx]; // RQ1
          d.win_cnt    = '0;
          d.settle_cnt = '0;
          d.enc        = kbe_pkg::KBE_SETTLE;
        end
      end
      kbe_pkg::KBE_SETTLE: begin
        if (!first_held) begin
          d.enc = kbe_pkg::KBE_IDLE;
        end else if (q.settle_cnt == SETTLE_LAST) begin // RQ5
          d.enc = kbe_pkg::KBE_HOLD;
          ev[kbe_pkg::KBE_EV_STROBE] = 1'b1;
        end else begin
          d.settle_cnt = q.settle_cnt + 22'h1;
        end
      end
      kbe_pkg::KBE_HOLD: begin
        if (!first_held) begin
          d.enc = kbe_pkg::KBE_IDLE;
        end else if (other_key) begin
          if (q.win_cnt < INTERLOCK_LIM) begin // RQ3
            d.second_idx = other_idx;
            d.enc        = kbe_pkg::KBE_PEND;
          end else begin
            d.first_idx  = other_idx;
            d.code       = KEY_ROM[other_idx]; // RQ1
            d.win_cnt    = '0;
            d.settle_cnt = '0;
            d.enc        = kbe_pkg::KBE_SETTLE;
          end
        end
      end
      kbe_pkg::KBE_PEND: begin
        if (!second_held) begin
          ev[kbe_pkg::KBE_EV_SUPPRESS] = 1'b1; // RQ3
          d.enc = first_held ? kbe_pkg::KBE_HOLD : kbe_pkg::KBE_IDLE;
        end else if (!first_held) begin
          d.first_idx  = q.second_idx;
          d.code       = KEY_ROM[q.second_idx];
          d.win_cnt    = '0;
          d.settle_cnt = '0;
          d.enc        = kbe_pkg::KBE_SETTLE;
        end
      end
    endcase

    // Strobe low while a settled key is held
    d.strobe_n      = ~((d.enc == kbe_pkg::KBE_HOLD) | (d.enc == kbe_pkg::KBE_PEND)); // RQ2 RQ4
    d.strobe_prev_n = q.strobe_n;

    // Ready flip-flops; a set in the clearing cycle wins
    if (rd_hit) begin
      d.clear_pend = 1'b1;
      d.bus_data   = q.code; // RQ9
      ev[kbe_pkg::KBE_EV_READ] = 1'b1;
    end
    if (q.clear_pend && t2_en) begin
      d.ready1     = 1'b0; // RQ13
      d.clear_pend = 1'b0;
    end
    if (ready1_set) begin
      d.ready1 = 1'b1; // RQ6
    end
    if (phase2_en) begin
      d.ready2 = q.ready1; // RQ7 RQ14
    end

    if (host_function_code_hit && host_req_in.host_function_code == kbe_pkg::KBE_HOST_FUNCTION_CODE_MASK) begin
      d.mask_ff = 1'b1; // RQ10
    end else if (host_function_code_hit && host_req_in.host_function_code == kbe_pkg::KBE_HOST_FUNCTION_CODE_UNMASK) begin
      d.mask_ff = 1'b0; // RQ10
    end

    if (wr_hit) begin
      d.repeat_en = 1'b1; // RQ12
    end else if (q.strobe_n) begin
      d.repeat_en = 1'b0;
    end

    if (!q.ready2) begin
      d.irq = 1'b0;
    end else if (gate_open && int_sel_in) begin
      d.irq = 1'b1; // RQ8
    end

    // Register port
    if (reg_req_in.wr) begin
      unique case (reg_req_in.addr)
        kbe_pkg::KBE_REG_CTRL:   d.ctrl_en = reg_req_in.wdata[kbe_pkg::KBE_CTRL_EN_BIT];
        kbe_pkg::KBE_REG_STATUS: w1c = reg_req_in.wdata[kbe_pkg::KBE_EV_W-1:0];
        kbe_pkg::KBE_REG_MASK:   d.ev_mask = reg_req_in.wdata[kbe_pkg::KBE_EV_W-1:0];
        default: begin
        end
      endcase
    end
    d.status = (q.status & ~w1c) | ev;

    d.rd_data = '0;
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        kbe_pkg::KBE_REG_CTRL:   d.rd_data = {7'h00, q.ctrl_en};
        kbe_pkg::KBE_REG_STATUS: d.rd_data = {5'h00, q.status};
        kbe_pkg::KBE_REG_MASK:   d.rd_data = {5'h00, q.ev_mask};
        kbe_pkg::KBE_REG_CODE:   d.rd_data = {q.ready2, q.code};
        default:                 d.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q               <= '0;
      q.enc           <= kbe_pkg::KBE_IDLE;
      q.strobe_n      <= 1'b1;
      q.strobe_prev_n <= 1'b1;
      q.ctrl_en       <= kbe_pkg::KBE_CTRL_EN_RST;
      q.mask_ff       <= kbe_pkg::KBE_MASKFF_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign key_code_out             = q.code; // RQ1
  assign key_data_strobe_n_out    = q.strobe_n; // RQ4
  assign int_sel_out              = int_sel_in & ~gate_open; // RQ8
  assign transfer_irq_request_out = q.irq;
  assign host_ack_out             = rd_hit | wr_hit | test_hit; // RQ9 RQ11
  assign host_in_bus_out          = {1'b0, q.bus_data};
  assign rd_data_out              = q.rd_data;
  assign irq_out                  = |(q.status & q.ev_mask);

endmodule

// *** kbe_assertions.sv ***
// Concurrent checks on the kbe_top ports.
// Assumes one clock and the async active-high reset of kbe_top.
module kbe_assertions (
  input wire logic                  clk_in,
  input wire logic                  rst_in,
  input wire logic [67:0]           key_switch_in,
  input wire logic                  keyboard_present_in,
  input wire logic                  device_type_select_in,
  input wire logic                  int_sel_in,
  input wire kbe_pkg::kbe_host_req_s host_req_in,
  input wire kbe_pkg::kbe_reg_req_s  reg_req_in,
  input wire logic [6:0]            key_code_out,
  input wire logic                  key_data_strobe_n_out,
  input wire logic                  int_sel_out,
  input wire logic                  transfer_irq_request_out,
  input wire logic                  host_ack_out,
  input wire logic [7:0]            host_in_bus_out,
  input wire logic [7:0]            rd_data_out
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire rq = host_req_in.read_io && host_req_in.addr_match;
  property p_write_ack; host_req_in.write_io && host_req_in.addr_match |-> host_ack_out; endproperty
  a_write_ack: assert property (p_write_ack) else $error("write not acknowledged");
  property p_test_absent;
    !keyboard_present_in [*4] ##0 (host_req_in.test_io && host_req_in.addr_match) |-> !host_ack_out;
  endproperty
  a_test_absent: assert property (p_test_absent) else $error("test acknowledged without keyboard");
  property p_read_bus; rq && host_ack_out |=> host_in_bus_out == {1'b0, $past(key_code_out)}; endproperty
  a_read_bus: assert property (p_read_bus) else $error("read bus data wrong");
  property p_code_stable;
    $fell(key_data_strobe_n_out) |-> $stable(key_code_out) && $past(key_code_out, 4) == key_code_out;
  endproperty
  a_code_stable: assert property (p_code_stable) else $error("code not settled at strobe");
  property p_strobe_cause; $fell(key_data_strobe_n_out) |-> $past(|key_switch_in, 3); endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without key");
  property p_chain_pass; !int_sel_in |-> !int_sel_out; endproperty
  a_chain_pass: assert property (p_chain_pass) else $error("select out without select in");
  property p_irq_cause;
    $rose(transfer_irq_request_out) |-> $past(int_sel_in && device_type_select_in);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without select");
  property p_withdraw; rq && host_ack_out |-> ##[1:12] !transfer_irq_request_out; endproperty
  a_withdraw: assert property (p_withdraw) else $error("interrupt not withdrawn");
  property p_rd_idle; !reg_req_in.rd |=> rd_data_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  c_strobe: cover property ($fell(key_data_strobe_n_out));
  c_read: cover property (rq && host_ack_out);
  c_irq: cover property ($rose(transfer_irq_request_out));
endmodule

bind kbe_top kbe_assertions u_kbe_assertions (.clk_in(clk_in), .rst_in(rst_in),
  .key_switch_in(key_switch_in), .keyboard_present_in(keyboard_present_in),
  .device_type_select_in(device_type_select_in), .int_sel_in(int_sel_in),
  .host_req_in(host_req_in), .reg_req_in(reg_req_in), .key_code_out(key_code_out),
  .key_data_strobe_n_out(key_data_strobe_n_out), .int_sel_out(int_sel_out),
  .transfer_irq_request_out(transfer_irq_request_out), .host_ack_out(host_ack_out),
  .host_in_bus_out(host_in_bus_out), .rd_data_out(rd_data_out));

// *** kbe_host_model.sv ***
// Host processor model: passes bench commands, answers interrupts with reads.
// Assumes the kbe_top host port on the same clock.
module kbe_host_model (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   auto_in,
  input  wire logic                   slow_in,
  input  wire logic                   go_in,
  input  wire kbe_pkg::kbe_host_req_s cmd_in,
  input  wire logic                   irq_in,
  input  wire logic                   ack_in,
  input  wire logic [7:0]             bus_in,
  output kbe_pkg::kbe_host_req_s      req_out,
  output logic                        got_v_out,
  output logic [6:0]                  got_out
);
  logic [4:0] wait_q;
  logic       cap_q;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      req_out <= '0;
      got_v_out <= 1'b0;
      got_out <= '0;
      wait_q <= '0;
      cap_q <= 1'b0;
    end else begin
      req_out <= '0;
      got_v_out <= cap_q;
      cap_q <= req_out.read_io && ack_in;
      if (cap_q) got_out <= bus_in[6:0];
      if (wait_q != 5'h0) wait_q <= wait_q - 5'h1;
      if (go_in) req_out <= cmd_in;
      else if (auto_in && irq_in && wait_q == 5'h0) wait_q <= slow_in ? 5'h14 : 5'hF;
      // Hold-off after each read outlasts the interrupt withdrawal
      if (wait_q == 5'hE) req_out <= {4'h8, 1'b1, 4'h0};
    end
  end
endmodule

// *** kbe_top_tb.sv ***
// Self-checking bench for kbe_top with a host model and random keys.
// Assumes short settle and interlock counts set at the instance.
module kbe_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 8;
  logic                   clk_in, rst_in, kp, device_type_select, isel, auto, slow, go;
  logic                   strb_n, isel_o, xirq, ack, irq, got_v;
  logic [67:0]            keys;
  kbe_pkg::kbe_host_req_s cmd, hreq;
  kbe_pkg::kbe_reg_req_s  rreq;
  logic [6:0]             code, got;
  logic [7:0]             hbus, rdat;
  logic [31:0]            rs;
  int                     fails, checks, n, k, d, i, nfall;
  int                     kix[4] = '{0, 16, 31, 25};
  kbe_top #(.SETTLE_CYCLES(SETTLE), .INTERLOCK_CYCLES(40)) u_kbe_top (.clk_in(clk_in), .rst_in(rst_in),
    .key_switch_in(keys), .keyboard_present_in(kp), .device_type_select_in(device_type_select), .int_sel_in(isel),
    .host_req_in(hreq), .reg_req_in(rreq), .key_code_out(code), .key_data_strobe_n_out(strb_n),
    .int_sel_out(isel_o), .transfer_irq_request_out(xirq), .host_ack_out(ack), .host_in_bus_out(hbus),
    .rd_data_out(rdat), .irq_out(irq));
  kbe_host_model u_kbe_host_model (.clk_in(clk_in), .rst_in(rst_in), .auto_in(auto), .slow_in(slow),
    .go_in(go), .cmd_in(cmd), .irq_in(xirq), .ack_in(ack), .bus_in(hbus), .req_out(hreq),
    .got_v_out(got_v), .got_out(got));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
  endfunction
  function automatic logic [6:0] rom(input int x);
    case (x)
      0: return 7'h68;
      16: return 7'h51;
      31: return 7'h41;
      default: return 7'h50;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask
  task automatic rw(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    rreq <= {a, v, 2'b10};
    @(posedge clk_in);
    rreq.wr <= 1'b0;
  endtask
  task automatic rr(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_in);
    rreq <= {a, 8'h00, 2'b01};
    @(posedge clk_in);
    rreq.rd <= 1'b0;
    #1 chk(nm, rdat, e);
  endtask
  // Kind bits: read, write, test, function
  task automatic hop(input string nm, input logic [3:0] kd, input logic [3:0] fc, input logic e);
    @(posedge clk_in);
    cmd <= {kd, 1'b1, fc};
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    #1 chk(nm, {7'h00, ack}, {7'h00, e});
  endtask
  task automatic strobe_wait(input logic lvl, output int c);
    for (c = 0; c < 40 && strb_n !== lvl; c++) @(posedge clk_in);
    #1 chk("strobe", {7'h00, strb_n}, {7'h00, lvl});
  endtask
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge strb_n) nfall++;
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    tick(20000);
    fails++;
    give_verdict();
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst_in = 1'b1; keys = '0; kp = 1'b1; device_type_select = 1'b1; isel = 1'b1; auto = 1'b0; slow = 1'b0; go = 1'b0;
    cmd = '0; rreq = '0; rs = 32'h4F81; fails = 0; checks = 0; nfall = 0;
    tick(5);
    rst_in <= 1'b0;
    chk("strobe_rst", {7'h00, strb_n}, 8'h01);
    rr("ctrl", 4'h0, 8'h01);
    rr("mask", 4'h8, 8'h00);
    rr("unmapped", 4'h2, 8'h00);
    rw(4'h0, 8'h00);
    keys <= 68'h1;
    tick(20);
    chk("disabled", {7'h00, strb_n}, 8'h01);
    keys <= '0;
    rw(4'h0, 8'h01);
    $display("test 1 done");
    auto <= 1'b1;
    for (n = 0; n < 4; n++) begin
      rs = lfsr(rs);
      k = kix[rs[1:0]];
      slow <= rs[2];
      keys <= 68'h1 << k;
      strobe_wait(1'b0, d);
      chk("delay", {7'h00, (d >= SETTLE) && (d <= SETTLE + 4)}, 8'h01);
      chk("code", {1'b0, code}, {1'b0, rom(k)});
      for (i = 0; i < 60 && got_v !== 1'b1; i++) @(posedge clk_in);
      chk("got", {1'b0, got}, {1'b0, rom(k)});
      tick(14);
      chk("withdraw", {7'h00, xirq}, 8'h00);
      hop("reread", 4'h8, 4'h0, 1'b0);
      keys <= '0;
      strobe_wait(1'b1, d);
    end
    $display("test 2 done");
    hop("test_present", 4'h2, 4'h0, 1'b1);
    kp <= 1'b0;
    tick(4);
    hop("test_absent", 4'h2, 4'h0, 1'b0);
    kp <= 1'b1;
    $display("test 3 done");
    hop("mask", 4'h1, 4'h2, 1'b0);
    keys <= 68'h1;
    strobe_wait(1'b0, d);
    tick(20);
    chk("masked", {6'h00, xirq, isel_o}, 8'h01);
    device_type_select <= 1'b0;
    hop("unmask", 4'h1, 4'h3, 1'b0);
    tick(4);
    chk("untyped", {6'h00, xirq, isel_o}, 8'h01);
    device_type_select <= 1'b1;
    for (i = 0; i < 10 && xirq !== 1'b1; i++) @(posedge clk_in);
    chk("unmasked", {7'h00, i < 10}, 8'h01);
    tick(30);
    keys <= '0;
    strobe_wait(1'b1, d);
    $display("test 4 done");
    rw(4'h4, 8'h07);
    nfall = 0;
    keys <= 68'h1;
    tick(6);
    keys <= 68'h1 | (68'h1 << 16);
    tick(10);
    keys <= 68'h1;
    tick(30);
    keys <= '0;
    strobe_wait(1'b1, d);
    chk("strobes", nfall[7:0], 8'h01);
    rr("status", 4'h4, 8'h07);
    chk("irq_masked", {7'h00, irq}, 8'h00);
    rw(4'h8, 8'h02);
    tick(2);
    chk("irq_set", {7'h00, irq}, 8'h01);
    rw(4'h4, 8'h02);
    tick(2);
    chk("irq_clear", {7'h00, irq}, 8'h00);
    rr("status_w1c", 4'h4, 8'h05);
    rw(4'h8, 8'h00);
    $display("test 5 done");
    auto <= 1'b0;
    isel <= 1'b0;
    keys <= 68'h1 << 31;
    strobe_wait(1'b0, d);
    tick(6);
    hop("write", 4'h4, 4'h0, 1'b1);
    for (n = 0; n < 3; n++) begin
      hop("repeat", 4'h8, 4'h0, 1'b1);
      tick(16);
      chk("bus", hbus, {1'b0, rom(31)});
    end
    rr("code_reg", 4'hC, {1'b1, rom(31)});
    keys <= '0;
    strobe_wait(1'b1, d);
    $display("test 6 done");
    give_verdict();
  end
endmodule
